// >>> design/ascan_consts.svh
// constants for the analog boundary-scan cells and their test controller
// assumes one 10 MHz clock shared by both ends
`ifndef ASCAN_CONSTS_SVH
`define ASCAN_CONSTS_SVH

// --------------------------------------------------
// chain layout, bit 0 leaves first
// --------------------------------------------------
`define CHAIN_LEN 23
`define POS_CMP_RESULT 0
`define POS_CMP_OFF 1
`define POS_CMP_MUX_SEL 2
`define POS_CMP_BG_EN 3
`define POS_CONV_RESULT 4
`define POS_AMP_CLK 5
`define POS_AMP_PATH_EN 6
`define POS_REF_NEG_EN 7
`define POS_CONV_PWR 8
`define POS_AMP_PWR 9
`define POS_DAC_LSB 10
`define POS_DAC_MSB 19
`define POS_BYPASS 20
`define POS_GND_EN 21
`define POS_SAMPLE_HOLD 22

// --------------------------------------------------
// reset values and the observe-cell mask
// --------------------------------------------------
`define IDLE_PATTERN 23'h580002
`define OBSERVE_MASK 23'h000011

// --------------------------------------------------
// controller register offsets and fields
// --------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_PATTERN 4'h4
`define OFS_RESULT 4'h8
`define OFS_STATUS 4'hc
`define CTRL_MODE_BIT 0
`define CTRL_START_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_CONFLICT_BIT 1

// --------------------------------------------------
// timing
// --------------------------------------------------
`define STEP_DIV 4

`endif

// >>> design/ascan_pkg.sv
// types shared by both ends of the analog scan link
// assumes ascan_consts.svh for the numbers
package ascan_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CAPTURE = 2'h1,
		ST_SHIFT = 2'h3,
		ST_UPDATE = 2'h2
	} scan_state_e;
endpackage

// >>> design/ascan_if.sv
// link between the test controller and the analog boundary-scan cells
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface ascan_if;
	logic test_mode;
	logic capture_dr;
	logic shift_dr;
	logic update_dr;
	logic scan_in;
	logic scan_out;
	modport cells (
		input test_mode, capture_dr, shift_dr, update_dr, scan_in,
		output scan_out
	);
	modport ctrl (
		output test_mode, capture_dr, shift_dr, update_dr, scan_in,
		input scan_out
	);
endinterface
`default_nettype wire

// >>> design/analog_scan_cells.sv
// boundary-scan cells on the comparator and converter control/observe signals
// assumes the analog results arrive asynchronously, link signals share clk_i
`include "ascan_consts.svh"
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - scan cell on every comparator signal
// - connectivity tests use port-pin cells instead
// - mux select routes converter mux; idle 0
// - comparator result observable, feeds program normally
// - scan cell on every converter signal
// - amplifier path enable; idle 0
// - bandgap to negative input; idle 0
// - converter power on; idle 0
// - amplifier power on; idle 0
// - ten-bit DAC value, idle 0x200
// - ground negative input; idle 0
// - sample low, hold high; idle 1
// - controller selects one negative-input source
module analog_scan_cells
	import ascan_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// scan link
	ascan_if.cells link,
	// functional values from the running logic, observe positions ignored
	input wire logic [`CHAIN_LEN-1:0] func_ctrl_i,
	// analog results
	input wire logic comparator_result_i,
	input wire logic converter_result_i,
	// comparator controls and synchronised result
	output logic comparator_off_o,
	output logic comparator_mux_input_select_o,
	output logic comparator_bandgap_enable_o,
	output logic comparator_result_o,
	// converter controls and synchronised result
	output logic amp_clock_o,
	output logic amp_to_compare_path_enable_o,
	output logic reference_to_negative_enable_o,
	output logic converter_power_on_o,
	output logic amplifier_power_on_o,
	output logic [9:0] dac_value_o,
	output logic amp_bypass_channel_connect_o,
	output logic negative_input_ground_enable_o,
	output logic sample_hold_o,
	output logic converter_result_o
);
	// safe pattern, one bit per cell, for the reset branches
	localparam logic [`CHAIN_LEN-1:0] IDLE_BITS = `IDLE_PATTERN;

	logic [1:0] cmp_sync;
	logic [1:0] conv_sync;
	logic [`CHAIN_LEN-1:0] shift_reg;
	logic [`CHAIN_LEN-1:0] chain_next;
	logic [`CHAIN_LEN-1:0] update_reg;
	logic [`CHAIN_LEN-1:0] selected;
	logic [`CHAIN_LEN-1:0] applied;
	logic [`CHAIN_LEN-1:0] observed;

	// --------------------------------------------------
	// cell kinds
	// --------------------------------------------------
	// observe-only cells carry an analog result back and drive nothing
	function automatic logic observe_cell(input int pos);
		return pos == `POS_CMP_RESULT || pos == `POS_CONV_RESULT;
	endfunction

	// the synchronised result that an observe-only cell captures
	function automatic logic observe_value(input int pos, input logic cmp, input logic conv);
		if (pos == `POS_CMP_RESULT) begin
			return cmp;
		end
		return conv;
	endfunction

	// --------------------------------------------------
	// result synchronisers
	// --------------------------------------------------
	// analog results move at any time, so only the second flop is read
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_sync <= 2'h0;
		end else begin
			cmp_sync <= {cmp_sync[0], comparator_result_i};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			conv_sync <= 2'h0;
		end else begin
			conv_sync <= {conv_sync[0], converter_result_i};
		end
	end

	// results reach the program as well as the chain
	assign comparator_result_o = cmp_sync[1];
	assign converter_result_o = conv_sync[1];

	// --------------------------------------------------
	// cell muxes
	// --------------------------------------------------
	// the update latch only reaches the analog side while test mode holds
	for (genvar i = 0; i < `CHAIN_LEN; i++) begin : g_select
		assign selected[i] = link.test_mode ? update_reg[i] : func_ctrl_i[i];
	end

	// control cells capture what they apply, observe cells the result
	for (genvar i = 0; i < `CHAIN_LEN; i++) begin : g_observe
		if (observe_cell(i)) begin : g_result
			assign observed[i] = observe_value(i, cmp_sync[1], conv_sync[1]);
		end else begin : g_control
			assign observed[i] = selected[i];
		end
	end

	// --------------------------------------------------
	// shift stage
	// --------------------------------------------------
	// one shared chain covers comparator and converter signals alike
	assign chain_next = {link.scan_in, shift_reg[`CHAIN_LEN-1:1]};
	assign link.scan_out = shift_reg[0];

	for (genvar i = 0; i < `CHAIN_LEN; i++) begin : g_shift
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				shift_reg[i] <= IDLE_BITS[i];
			end else if (link.capture_dr) begin
				shift_reg[i] <= observed[i];
			end else if (link.shift_dr) begin
				shift_reg[i] <= chain_next[i];
			end
		end
	end

	// --------------------------------------------------
	// update stage
	// --------------------------------------------------
	// reset to the safe pattern so entering test mode starts idle
	for (genvar i = 0; i < `CHAIN_LEN; i++) begin : g_update
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				update_reg[i] <= IDLE_BITS[i];
			end else if (link.update_dr && link.test_mode) begin
				update_reg[i] <= shift_reg[i];
			end
		end
	end

	// --------------------------------------------------
	// drive stage
	// --------------------------------------------------
	// pins leave from flops one cycle behind the mux, safe while in reset
	for (genvar i = 0; i < `CHAIN_LEN; i++) begin : g_drive
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				applied[i] <= IDLE_BITS[i];
			end else begin
				applied[i] <= selected[i];
			end
		end
	end

	// --------------------------------------------------
	// comparator-side outputs
	// --------------------------------------------------
	assign comparator_off_o = applied[`POS_CMP_OFF];
	assign comparator_mux_input_select_o = applied[`POS_CMP_MUX_SEL];
	assign comparator_bandgap_enable_o = applied[`POS_CMP_BG_EN];

	// --------------------------------------------------
	// converter-side outputs
	// --------------------------------------------------
	assign amp_clock_o = applied[`POS_AMP_CLK];
	assign amp_to_compare_path_enable_o = applied[`POS_AMP_PATH_EN];
	assign reference_to_negative_enable_o = applied[`POS_REF_NEG_EN];
	assign converter_power_on_o = applied[`POS_CONV_PWR];
	assign amplifier_power_on_o = applied[`POS_AMP_PWR];
	assign dac_value_o = applied[`POS_DAC_MSB:`POS_DAC_LSB];
	assign amp_bypass_channel_connect_o = applied[`POS_BYPASS];
	assign negative_input_ground_enable_o = applied[`POS_GND_EN];
	assign sample_hold_o = applied[`POS_SAMPLE_HOLD];
endmodule
`default_nettype wire

// >>> design/analog_scan_ctrl.sv
// test controller that loads and reads the analog scan chain
// assumes a plain register port and the cells on the same clock
//
// Decided for this implementation: the address map and the address-and-strobe port.
`include "ascan_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module analog_scan_ctrl
	import ascan_pkg::*;
#(
	parameter int STEP_DIV = `STEP_DIV
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// scan link
	ascan_if.ctrl link
);
	scan_state_e state;
	logic [`CHAIN_LEN-1:0] pattern;
	logic [`CHAIN_LEN-1:0] result;
	logic [`CHAIN_LEN-1:0] shreg;
	logic [4:0] bit_cnt;
	logic [7:0] div_cnt;
	logic tick;
	logic mode;
	logic conflict;
	logic start_req;
	logic bad_pattern;

	// --------------------------------------------------
	// pacing divider
	// --------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt <= 8'h0;
		end else if (div_cnt == 8'(STEP_DIV - 1)) begin
			div_cnt <= 8'h0;
		end else begin
			div_cnt <= div_cnt + 8'h1;
		end
	end
	assign tick = (div_cnt == 8'(STEP_DIV - 1));

	// --------------------------------------------------
	// registers
	// --------------------------------------------------
	// only one negative-input source may be chosen at once
	assign bad_pattern = pattern[`POS_REF_NEG_EN] & pattern[`POS_GND_EN];
	assign start_req = wr_i && addr_i == `OFS_CTRL && wdata_i[`CTRL_START_BIT];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode <= 1'b0;
		end else if (wr_i && addr_i == `OFS_CTRL) begin
			mode <= wdata_i[`CTRL_MODE_BIT];
		end
	end

	// safe values stand in the pattern until software changes them
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pattern <= `IDLE_PATTERN;
		end else if (wr_i && addr_i == `OFS_PATTERN && state == ST_IDLE) begin
			pattern <= wdata_i[`CHAIN_LEN-1:0];
		end
	end

	// a refused start sets the flag; set wins over a clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			conflict <= 1'b0;
		end else if (start_req && state == ST_IDLE && bad_pattern) begin
			conflict <= 1'b1;
		end else if (wr_i && addr_i == `OFS_STATUS && wdata_i[`STAT_CONFLICT_BIT]) begin
			conflict <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0;
		end else if (rd_i) begin
			case (addr_i)
				`OFS_CTRL: rdata_o <= {31'h0, mode};
				`OFS_PATTERN: rdata_o <= {9'h0, pattern};
				`OFS_RESULT: rdata_o <= {9'h0, result};
				`OFS_STATUS: rdata_o <= {30'h0, conflict, state != ST_IDLE};
				default: rdata_o <= 32'h0;
			endcase
		end
	end

	// --------------------------------------------------
	// sequencer
	// --------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			bit_cnt <= 5'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_req && !bad_pattern) begin
						state <= ST_CAPTURE;
					end
				end
				ST_CAPTURE: begin
					if (tick) begin
						state <= ST_SHIFT;
						bit_cnt <= 5'h0;
					end
				end
				ST_SHIFT: begin
					if (tick) begin
						bit_cnt <= bit_cnt + 5'h1;
						if (bit_cnt == 5'(`CHAIN_LEN - 1)) begin
							state <= ST_UPDATE;
						end
					end
				end
				ST_UPDATE: begin
					if (tick) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shreg <= `IDLE_PATTERN;
		end else if (state == ST_IDLE && start_req) begin
			shreg <= pattern;
		end else if (link.shift_dr) begin
			shreg <= {link.scan_out, shreg[`CHAIN_LEN-1:1]};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			result <= `CHAIN_LEN'(0);
		end else if (link.update_dr) begin
			result <= shreg;
		end
	end

	// --------------------------------------------------
	// link drive
	// --------------------------------------------------
	assign link.test_mode = mode;
	assign link.capture_dr = tick && state == ST_CAPTURE;
	assign link.shift_dr = tick && state == ST_SHIFT;
	assign link.update_dr = tick && state == ST_UPDATE;
	assign link.scan_in = shreg[0];
endmodule
`default_nettype wire

// >>> testbench/ascan_monitor.sv
// assertions on the scan link between controller and cells
// assumes the controller runs with STEP_DIV of 4
`timescale 1ns/1ns
`default_nettype none
module ascan_monitor (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// scan link
	input wire logic test_mode,
	input wire logic capture_dr,
	input wire logic shift_dr,
	input wire logic update_dr,
	input wire logic scan_in,
	input wire logic scan_out
);
	// --------------------------------------------------
	// shift counter
	// --------------------------------------------------
	logic [4:0] shifts;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shifts <= 5'h0;
		end else if (capture_dr) begin
			shifts <= 5'h0;
		end else if (shift_dr) begin
			shifts <= shifts + 5'h1;
		end
	end
	// --------------------------------------------------
	// link rules
	// --------------------------------------------------
	strobe_onehot_a: assert property ($onehot0({capture_dr, shift_dr, update_dr}))
		else $error("two scan strobes at once");
	first_shift_a: assert property (capture_dr |-> ##4 shift_dr)
		else $error("no shift one step after capture");
	shift_gap_a: assert property (shift_dr |=> !(capture_dr || shift_dr || update_dr) [*3])
		else $error("strobe inside a step");
	shift_next_a: assert property (shift_dr |-> ##4 (shift_dr || update_dr))
		else $error("shift not followed by shift or update");
	shift_count_a: assert property (shift_dr |-> shifts < 5'd23)
		else $error("too many shifts");
	update_count_a: assert property (update_dr |-> shifts == 5'd23)
		else $error("update after wrong shift count");
	link_quiet_a: assert property (shift_dr |-> ##2 ($stable(scan_in) && $stable(scan_out)) [*2])
		else $error("scan data moved between shifts");
	scan_mode_a: assert property (capture_dr |-> test_mode)
		else $error("scan outside test mode");
endmodule
`default_nettype wire

// >>> testbench/analog_boundary_scan_cells_bench.sv
// self-checking bench: controller and cells joined by the scan link
// assumes the design constants header and one 10 MHz clock
`include "ascan_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module analog_boundary_scan_cells_bench;
	import ascan_pkg::*;
	logic clk_i, rst_i, wr_i, rd_i, cres, vres, vout;
	logic [3:0] addr_i;
	logic [31:0] wdata_i, rdata_o, s;
	logic [22:0] func, prev, p;
	logic [9:0] dac;
	logic [11:0] b;
	int num_errors, comparisons, n;
	ascan_if link();
	analog_scan_cells u_analog_scan_cells (.clk_i(clk_i), .rst_i(rst_i), .link(link),
		.func_ctrl_i(func), .comparator_result_i(cres), .converter_result_i(vres),
		.comparator_off_o(b[0]), .comparator_mux_input_select_o(b[1]),
		.comparator_bandgap_enable_o(b[2]), .comparator_result_o(b[3]), .amp_clock_o(b[4]),
		.amp_to_compare_path_enable_o(b[5]), .reference_to_negative_enable_o(b[6]),
		.converter_power_on_o(b[7]), .amplifier_power_on_o(b[8]), .dac_value_o(dac),
		.amp_bypass_channel_connect_o(b[9]), .negative_input_ground_enable_o(b[10]),
		.sample_hold_o(b[11]), .converter_result_o(vout));
	analog_scan_ctrl u_analog_scan_ctrl (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
	ascan_monitor u_ascan_monitor (.clk_i(clk_i), .rst_i(rst_i), .test_mode(link.test_mode),
		.capture_dr(link.capture_dr), .shift_dr(link.shift_dr), .update_dr(link.update_dr),
		.scan_in(link.scan_in), .scan_out(link.scan_out));
	// --------------------------------------------------
	// helpers
	// --------------------------------------------------
	function automatic logic [22:0] applied();
		return {b[11:9], dac, b[8:4], 1'b0, b[2:0], 1'b0};
	endfunction
	function automatic logic [22:0] ctl(logic [22:0] v);
		return v & ~`OBSERVE_MASK;
	endfunction
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		s = rdata_o;
		// back on a rising edge so the next stimulus lands there
		@(posedge clk_i);
	endtask
	// a refused start never raises busy, so the poll ends at once
	task automatic scan(logic [22:0] v);
		wr(`OFS_PATTERN, {9'h0, v});
		wr(`OFS_CTRL, 32'h3);
		n = 0;
		do begin
			rd(`OFS_STATUS);
			n++;
		end while (s[0] === 1'b1 && n < 100);
		check("busy", {31'h0, n >= 100}, 32'h0);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// --------------------------------------------------
	// clock, watchdog, tests
	// --------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'hdce50384));
		{wr_i, rd_i, cres, vres, addr_i, wdata_i} = '0;
		func = 23'($urandom);
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		check("functional path", applied(), ctl(func));
		rd(`OFS_PATTERN);
		check("pattern reset", s, `IDLE_PATTERN);
		rd(4'h2);
		check("unmapped read", s, 32'h0);
		$display("reset test done");
		cres <= 1'b1;
		repeat (4) @(posedge clk_i);
		scan(`IDLE_PATTERN);
		check("idle applied", applied(), ctl(`IDLE_PATTERN));
		check("comparator result", b[3], 1'b1);
		rd(`OFS_RESULT);
		check("idle capture", s, ctl(`IDLE_PATTERN) | 23'h1);
		cres <= 1'b0;
		repeat (4) @(posedge clk_i);
		check("comparator idle", b[3], 1'b0);
		$display("idle test done");
		prev = `IDLE_PATTERN;
		for (int i = 0; i < 6; i++) begin
			p = (i == 0) ? 23'h5fffff : (i == 1) ? 23'h0 : 23'($urandom);
			if (p[7] && p[21]) p[21] = 1'b0;
			cres <= 1'($urandom);
			vres <= 1'($urandom);
			func <= 23'($urandom);
			repeat (4) @(posedge clk_i);
			scan(p);
			check("applied", applied(), ctl(p));
			rd(`OFS_RESULT);
			check("capture", s, ctl(prev) | {vres, 3'h0, cres});
			check("converter result", vout, vres);
			prev = p;
		end
		$display("random test done");
		scan(`IDLE_PATTERN | 23'h200080);
		rd(`OFS_STATUS);
		check("conflict flag", s & 32'h3, 32'h2);
		check("refused keeps", applied(), ctl(prev));
		wr(`OFS_STATUS, 32'h2);
		rd(`OFS_STATUS);
		check("flag cleared", s & 32'h3, 32'h0);
		wr(`OFS_CTRL, 32'h0);
		repeat (2) @(negedge clk_i);
		check("mode off", applied(), ctl(func));
		$display("conflict test done");
		print_verdict();
	end
endmodule
`default_nettype wire
